// file: src/spi_eeprom_pkg.sv
package spi_eeprom_pkg;

  localparam int unsigned CLK_HZ = 100_000_000;
  // Self-timed write ceiling in milliseconds and as a longest time in cycles.
  localparam int unsigned SELF_TIMED_WRITE_TIME_MS = 5;
  localparam int unsigned SELF_TIMED_WRITE_CYCLES  = SELF_TIMED_WRITE_TIME_MS * (CLK_HZ / 1000);
  // Power-up readiness in microseconds; the device is ready at the early figure.
  localparam int unsigned POWERUP_TO_READ_DELAY_US  = 100;
  localparam int unsigned POWERUP_TO_WRITE_DELAY_US = 100;
  localparam int unsigned POWERUP_CYCLES = POWERUP_TO_READ_DELAY_US * (CLK_HZ / 1_000_000);

  localparam logic [7:0] OP_WRITE_ENABLE  = 8'h06;
  localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
  localparam logic [7:0] STATUS_READ_CMD  = 8'h05;
  localparam logic [7:0] OP_STATUS_WRITE  = 8'h01;
  localparam logic [7:0] OP_READ          = 8'h03;
  localparam logic [7:0] OP_WRITE         = 8'h02;

  localparam int unsigned ST_BUSY_BIT    = 0;
  localparam int unsigned ST_WEL_BIT     = 1;
  localparam int unsigned ST_PROTECT_BIT = 7;
  localparam logic [7:0]  ST_WRITE_MASK  = 8'h8C;
  localparam logic [7:0]  STATUS_RESET   = 8'h00;
  localparam int unsigned ADDR_W = 15;
  localparam int unsigned DEPTH  = 32768;

  typedef enum logic [2:0] {
    PH_CMD    = 3'b000,
    PH_ADDR   = 3'b001,
    PH_RDATA  = 3'b010,
    PH_WDATA  = 3'b011,
    PH_SWRITE = 3'b100,
    PH_STAT   = 3'b101,
    PH_IGNORE = 3'b110
  } phase_t;

  typedef struct packed {
    logic sel_b;
    logic sclk;
    logic mosi;
    logic protect_b;
    logic hold_b;
  } pins_t;

endpackage

// file: src/spi_eeprom_serial_port.sv
`timescale 1ns/1ps
module spi_eeprom_serial_port #(
  parameter int unsigned WRITE_CYCLES   = spi_eeprom_pkg::SELF_TIMED_WRITE_CYCLES,
  parameter int unsigned POWERUP_CYCLES = spi_eeprom_pkg::POWERUP_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_b,
  input  wire logic sel_b,
  input  wire logic sclk,
  input  wire logic mosi,
  input  wire logic protect_b,
  input  wire logic hold_b,
  output logic      miso,
  output logic      miso_oe,
  output logic      busy,
  output logic      ready
);

  spi_eeprom_pkg::pins_t meta_q;
  spi_eeprom_pkg::pins_t sync_q;
  spi_eeprom_pkg::pins_t prev_q;
  spi_eeprom_pkg::phase_t phase_q;
  logic [7:0]  shift_q;
  logic [2:0]  bit_cnt_q;
  logic [15:0] addr_q;
  logic [7:0]  status_q;
  logic [7:0]  tx_q;
  logic        pend_q;
  logic        pend_st_q;
  logic [7:0]  wbyte_q;
  logic [31:0] wcnt_q;
  logic [31:0] pcnt_q;
  logic [7:0]  mem [spi_eeprom_pkg::DEPTH];

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      meta_q <= '{sel_b: 1'b1, sclk: 1'b0, mosi: 1'b0, protect_b: 1'b1, hold_b: 1'b1};
      sync_q <= '{sel_b: 1'b1, sclk: 1'b0, mosi: 1'b0, protect_b: 1'b1, hold_b: 1'b1};
      prev_q <= '{sel_b: 1'b1, sclk: 1'b0, mosi: 1'b0, protect_b: 1'b1, hold_b: 1'b1};
    end else begin
      meta_q <= '{sel_b: sel_b, sclk: sclk, mosi: mosi, protect_b: protect_b, hold_b: hold_b};
      sync_q <= meta_q;
      prev_q <= sync_q;
    end
  end

  logic held;
  logic active;
  logic rise;
  logic fall;
  logic sess_start;
  logic sess_end;
  logic [7:0] rx_byte;
  logic byte_done;
  logic hw_locked;

  // A pause freezes the bit counter, so the frame resumes where it stopped.
  // Hold bites one sample late, so a clock edge that lands with the hold edge is still served.
  assign held       = !sync_q.hold_b && !prev_q.hold_b;
  assign active     = !sync_q.sel_b && !held && ready;
  assign rise       = active && sync_q.sclk && !prev_q.sclk;
  assign fall       = active && !sync_q.sclk && prev_q.sclk;
  assign sess_start = !sync_q.sel_b && prev_q.sel_b;
  assign sess_end   = sync_q.sel_b && !prev_q.sel_b;
  assign rx_byte    = {shift_q[6:0], sync_q.mosi};
  assign byte_done  = rise && (bit_cnt_q == 3'h7);
  assign hw_locked  = !sync_q.protect_b && status_q[spi_eeprom_pkg::ST_PROTECT_BIT];

  function automatic spi_eeprom_pkg::phase_t decode_op(input logic [7:0] op,
                                                       input logic       wip);
    if (wip && op != spi_eeprom_pkg::STATUS_READ_CMD) begin
      decode_op = spi_eeprom_pkg::PH_IGNORE;
    end else if (op == spi_eeprom_pkg::STATUS_READ_CMD) begin
      decode_op = spi_eeprom_pkg::PH_STAT;
    end else if (op == spi_eeprom_pkg::OP_READ || op == spi_eeprom_pkg::OP_WRITE) begin
      decode_op = spi_eeprom_pkg::PH_ADDR;
    end else if (op == spi_eeprom_pkg::OP_STATUS_WRITE) begin
      decode_op = spi_eeprom_pkg::PH_SWRITE;
    end else begin
      decode_op = spi_eeprom_pkg::PH_IGNORE;
    end
  endfunction

  logic is_read_q;
  logic [7:0] op_q;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_q   <= spi_eeprom_pkg::PH_CMD;
      shift_q   <= 8'h00;
      bit_cnt_q <= 3'h0;
      addr_q    <= 16'h0000;
      op_q      <= 8'h00;
      is_read_q <= 1'b0;
    end else if (sync_q.sel_b || sess_start) begin
      phase_q   <= spi_eeprom_pkg::PH_CMD;
      bit_cnt_q <= 3'h0;
      shift_q   <= 8'h00;
    end else if (rise) begin
      shift_q   <= rx_byte;
      bit_cnt_q <= bit_cnt_q + 3'h1;
      if (byte_done) begin
        case (phase_q)
          spi_eeprom_pkg::PH_CMD: begin
            op_q      <= rx_byte;
            is_read_q <= (rx_byte == spi_eeprom_pkg::OP_READ);
            phase_q   <= decode_op(rx_byte, busy);
          end
          spi_eeprom_pkg::PH_ADDR: begin
            addr_q <= {addr_q[7:0], rx_byte};
            if (op_q == 8'hFF) begin
              phase_q <= is_read_q ? spi_eeprom_pkg::PH_RDATA : spi_eeprom_pkg::PH_WDATA;
            end
            op_q <= 8'hFF;
          end
          spi_eeprom_pkg::PH_RDATA: addr_q <= addr_q + 16'h0001;
          default: phase_q <= phase_q;
        endcase
      end
    end
  end

  // Single byte writes only; page buffering is beyond this port.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q  <= spi_eeprom_pkg::STATUS_RESET;
      pend_q    <= 1'b0;
      pend_st_q <= 1'b0;
      wbyte_q   <= 8'h00;
    end else begin
      if (sess_start) begin
        pend_q    <= 1'b0;
        pend_st_q <= 1'b0;
      end
      if (byte_done && phase_q == spi_eeprom_pkg::PH_CMD && !busy) begin
        if (rx_byte == spi_eeprom_pkg::OP_WRITE_ENABLE) begin
          status_q[spi_eeprom_pkg::ST_WEL_BIT] <= 1'b1;
        end else if (rx_byte == spi_eeprom_pkg::OP_WRITE_DISABLE) begin
          status_q[spi_eeprom_pkg::ST_WEL_BIT] <= 1'b0;
        end
      end
      if (byte_done && status_q[spi_eeprom_pkg::ST_WEL_BIT]) begin
        if (phase_q == spi_eeprom_pkg::PH_WDATA) begin
          wbyte_q <= rx_byte;
          pend_q  <= 1'b1;
        end else if (phase_q == spi_eeprom_pkg::PH_SWRITE && !hw_locked) begin
          wbyte_q   <= rx_byte;
          pend_st_q <= 1'b1;
        end
      end
      if (sess_end && (pend_q || pend_st_q)) begin
        if (pend_st_q) begin
          status_q[7:2] <= (wbyte_q[7:2] & spi_eeprom_pkg::ST_WRITE_MASK[7:2]);
        end
        status_q[spi_eeprom_pkg::ST_WEL_BIT] <= 1'b0;
        pend_q    <= 1'b0;
        pend_st_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sess_end && pend_q) begin
      mem[addr_q[spi_eeprom_pkg::ADDR_W-1:0]] <= wbyte_q;
    end
  end

  // The write timer loads its ceiling on the closing select edge and counts down to zero.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      wcnt_q <= 32'h0000_0000;
    end else if (sess_end && (pend_q || pend_st_q)) begin
      wcnt_q <= 32'(WRITE_CYCLES);
    end else if (wcnt_q != 32'h0000_0000) begin
      wcnt_q <= wcnt_q - 32'h0000_0001;
    end
  end
  assign busy = (wcnt_q != 32'h0000_0000);

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pcnt_q <= 32'(POWERUP_CYCLES);
    end else if (pcnt_q != 32'h0000_0000) begin
      pcnt_q <= pcnt_q - 32'h0000_0001;
    end
  end
  assign ready = (pcnt_q == 32'h0000_0000);

  // The next byte loads on the falling edge after the last bit of the previous one.
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_q <= 8'h00;
      miso <= 1'b0;
    end else if (fall) begin
      if (bit_cnt_q == 3'h0) begin
        if (phase_q == spi_eeprom_pkg::PH_STAT) begin
          tx_q <= {status_q[7:1], busy} << 1;
          miso <= busy ? 1'b1 : status_q[7];
          if (busy) tx_q <= 8'hFF;
        end else if (phase_q == spi_eeprom_pkg::PH_RDATA) begin
          tx_q <= mem[addr_q[spi_eeprom_pkg::ADDR_W-1:0]] << 1;
          miso <= mem[addr_q[spi_eeprom_pkg::ADDR_W-1:0]][7];
        end
      end else begin
        miso <= tx_q[7];
        tx_q <= tx_q << 1;
      end
    end
  end

  assign miso_oe = !sync_q.sel_b && !held &&
                   (phase_q == spi_eeprom_pkg::PH_RDATA || phase_q == spi_eeprom_pkg::PH_STAT);

  AST_RELEASE_DESELECT: assert property (@(posedge core_clk) disable iff (!rst_b)
    sync_q.sel_b |-> !miso_oe) else $error("output driven while deselected");
  AST_RELEASE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_b)
    held |-> !miso_oe) else $error("output driven while held");
  AST_HOLD_FREEZE: assert property (@(posedge core_clk) disable iff (!rst_b)
    (held && !sync_q.sel_b) |=> $stable(bit_cnt_q)) else $error("counter moved in hold");
  AST_BIT_RISE: assert property (@(posedge core_clk) disable iff (!rst_b)
    rise && !sess_start |=> bit_cnt_q == $past(bit_cnt_q) + 3'h1) else $error("bit lost");
  AST_OUT_FALL: assert property (@(posedge core_clk) disable iff (!rst_b)
    !fall |=> $stable(miso)) else $error("output moved off falling edge");
  AST_SESSION_RESET: assert property (@(posedge core_clk) disable iff (!rst_b)
    sess_start |=> phase_q == spi_eeprom_pkg::PH_CMD) else $error("session not reset");
  AST_LOCKED_STATUS: assert property (@(posedge core_clk) disable iff (!rst_b)
    byte_done && phase_q == spi_eeprom_pkg::PH_SWRITE && hw_locked |=> !pend_st_q)
    else $error("locked status write accepted");
  // The timer must drop by one every busy cycle, so busy can never outlast its ceiling.
  AST_WRITE_BOUND: assert property (@(posedge core_clk) disable iff (!rst_b)
    busy && !(sess_end && (pend_q || pend_st_q)) |=> wcnt_q == $past(wcnt_q) - 32'h0000_0001)
    else $error("write timer stalled");
  AST_BUSY_IGNORE: assert property (@(posedge core_clk) disable iff (!rst_b)
    byte_done && phase_q == spi_eeprom_pkg::PH_CMD && busy &&
    rx_byte != spi_eeprom_pkg::STATUS_READ_CMD |=> phase_q == spi_eeprom_pkg::PH_IGNORE)
    else $error("command taken while busy");
  COV_WRITE: cover property (@(posedge core_clk) disable iff (!rst_b) sess_end && pend_q);
  COV_STAT: cover property (@(posedge core_clk) disable iff (!rst_b)
    phase_q == spi_eeprom_pkg::PH_STAT && miso_oe);
  COV_HOLD: cover property (@(posedge core_clk) disable iff (!rst_b) held && !sync_q.sel_b);

endmodule

// file: tb/spi_eeprom_serial_port_tb_top.sv
`timescale 1ns/1ps
module spi_eeprom_serial_port_tb_top;
  localparam int unsigned WC = 500;
  localparam int unsigned PU = 20;
  logic core_clk, rst_b, protect_b, sel_b, sclk, mosi, hold_b, held;
  logic miso, miso_oe, busy, ready;
  logic [7:0] s;
  int   n_errors, check_count;
  // A released output shows the inverse of its last value.
  wire  logic miso_pin = miso_oe ? miso : ~miso;

  spi_eeprom_serial_port #(.WRITE_CYCLES(WC), .POWERUP_CYCLES(PU)) i_spi_eeprom_serial_port (
    .core_clk(core_clk), .rst_b(rst_b), .sel_b(sel_b), .sclk(sclk), .mosi(mosi),
    .protect_b(protect_b), .hold_b(hold_b), .miso(miso), .miso_oe(miso_oe),
    .busy(busy), .ready(ready));
  spi_host_model i_spi_host_model (.sel_b(sel_b), .sclk(sclk), .mosi(mosi),
    .hold_b(hold_b), .held(held), .miso(miso_pin));

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic check(input logic ok, input string msg);
    check_count++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask

  task automatic summarize();
    $display("errors %0d checks %0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic frame(input logic [7:0] op, input logic [23:0] args, input int n,
                       input int hold_at, output logic [7:0] last);
    @(posedge core_clk) #1;
    i_spi_host_model.start();
    i_spi_host_model.xfer(op, -1, last);
    for (int k = 0; k < n; k++) i_spi_host_model.xfer(args[23-8*k -: 8], (k == n-1) ? hold_at : -1, last);
    i_spi_host_model.stop();
    check(miso_oe === 1'b0, "output not released");
  endtask

  task automatic wait_write(input bit probe);
    realtime t0;
    t0 = $realtime - 200;
    repeat (10) @(posedge core_clk);
    check(busy === 1'b1, "write did not start");
    if (probe) begin
      frame(8'h06, 24'h0, 0, -1, s);
      frame(8'h05, 24'h0, 1, -1, s);
      check(s === 8'hFF, "status while busy");
    end
    for (int i = 0; i < WC + 400 && busy !== 1'b0; i++) @(posedge core_clk);
    check($realtime - t0 <= WC * 10.0 + 300, "write too long");
  endtask

  task automatic t_opcodes();
    logic [7:0] ops[4] = '{8'h05, 8'h06, 8'hA5, 8'h04};
    logic [7:0] exp[4] = '{8'h00, 8'h02, 8'h02, 8'h00};
    for (int k = 0; k < 4; k++) begin
      i_spi_host_model.set_mode(k >= 2);
      frame(ops[k], 24'h0, 0, -1, s);
      frame(8'h05, 24'h0, 1, -1, s);
      check(s === exp[k], "opcode effect on status");
    end
    i_spi_host_model.set_mode(1'b0);
  endtask

  task automatic t_protect();
    frame(8'h06, 24'h0, 0, -1, s);
    frame(8'h01, 24'h8C0000, 1, -1, s);
    wait_write(1'b1);
    frame(8'h05, 24'h0, 1, -1, s);
    check(s === 8'h8C, "status write");
    @(posedge core_clk) #1 protect_b = 1'b0;
    frame(8'h06, 24'h0, 0, -1, s);
    frame(8'h01, 24'h000000, 1, -1, s);
    repeat (20) @(posedge core_clk);
    check(busy === 1'b0, "protected write started");
    frame(8'h05, 24'h0, 1, -1, s);
    check((s & 8'hFD) === 8'h8C, "protected status changed");
    @(posedge core_clk) #1 protect_b = 1'b1;
    frame(8'h06, 24'h0, 0, -1, s);
    frame(8'h01, 24'h000000, 1, -1, s);
    wait_write(1'b0);
    frame(8'h05, 24'h0, 1, -1, s);
    check(s === 8'h00, "status restore");
  endtask

  task automatic t_hold_read();
    frame(8'h06, 24'h0, 0, -1, s);
    frame(8'h02, 24'h00125A, 3, -1, s);
    wait_write(1'b0);
    frame(8'h03, 24'h001200, 3, 4, s);
    check(s === 8'h5A, "read across hold");
  endtask

  always @(posedge core_clk) if (held === 1'b1) check(miso_oe === 1'b0, "driven in hold");

  initial begin
    #300_000;
    check(1'b0, "watchdog");
    summarize();
  end

  initial begin
    rst_b = 1'b0;
    protect_b = 1'b1;
    n_errors = 0;
    check_count = 0;
    repeat (16) @(posedge core_clk);
    check(miso_oe === 1'b0 && busy === 1'b0 && ready === 1'b0, "reset values");
    #1 rst_b = 1'b1;
    repeat (PU + 5) @(posedge core_clk);
    check(ready === 1'b1, "not ready");
    t_opcodes();
    t_protect();
    t_hold_read();
    summarize();
  end
endmodule

// file: tb/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic      sel_b,
  output logic      sclk,
  output logic      mosi,
  output logic      hold_b,
  output logic      held,
  input  wire logic miso
);
  logic cpol;

  initial begin
    cpol   = 1'b0;
    sel_b  = 1'b1;
    sclk   = 1'b0;
    mosi   = 1'b0;
    hold_b = 1'b1;
    held   = 1'b0;
  end

  // Mode 3 idles the serial clock high; hold is exercised in mode 0 only.
  task automatic set_mode(input logic m);
    cpol = m;
    sclk = m;
    #200;
  endtask

  task automatic start();
    #100 sel_b = 1'b0;
    #100;
  endtask

  // The data line is flipped after each frame so a stale bit can never pass as valid.
  task automatic stop();
    #100 sel_b = 1'b1;
    mosi = ~mosi;
    #200;
  endtask

  task automatic xfer(input logic [7:0] tx, input int hold_at, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == hold_at) begin
        hold_b = 1'b0;
        #200 held = 1'b1;
        #300 held = 1'b0;
        hold_b = 1'b1;
        #100;
      end
      if (cpol) sclk = 1'b0;
      mosi = tx[i];
      #62.5 sclk = 1'b1;
      rx[i] = miso;
      #62.5;
      if (!cpol) sclk = 1'b0;
    end
  endtask
endmodule
